/* boiu_pkg.sv */
// constants for the bit-operation instruction unit
package boiu_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BSEL_W = 3;
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 10;
    localparam int BSEL_MSB = 9;
    localparam int BSEL_LSB = 7;
    localparam int ADDR_MSB = 6;
    localparam int ADDR_LSB = 0;
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_BIT_TEST_CLEAR = 4'h6;
    typedef enum logic [1:0] {
        BOIU_Q1,
        BOIU_Q2,
        BOIU_Q3,
        BOIU_Q4
    } boiu_phase_e;
    typedef enum logic [1:0] {
        BOIU_OP_NONE,
        BOIU_OP_CLEAR,
        BOIU_OP_SET,
        BOIU_OP_TEST
    } boiu_op_e;
endpackage

/* boiu_bit_op_unit.sv */
// bit clear, bit set and bit test-skip execution over a four-phase instruction cycle
`timescale 1ns/1ps
module boiu_bit_op_unit
    import boiu_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int AW = ADDR_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // fetch stage
    input wire logic [INSN_W-1:0] insn_word,
    input wire logic insn_valid,
    // register file
    output logic [AW-1:0] reg_addr,
    output logic reg_rd_en,
    input wire logic [DW-1:0] reg_rd_data,
    output logic reg_wr_en,
    output logic [DW-1:0] reg_wr_data,
    // sequencer
    output logic [1:0] phase,
    output logic insn_done,
    output logic skip_next,
    output logic nop_cycle
);
    // phase and operand registers
    boiu_phase_e phase_q, phase_d;
    boiu_op_e op_q, op_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [BSEL_W-1:0] bsel_q, bsel_d;

    // datapath registers
    logic [DW-1:0] data_q, data_d;
    logic [DW-1:0] wr_q, wr_d;
    logic wr_en_q, wr_en_d;

    // sequencer registers
    logic skip_q, skip_d;
    logic nop_q, nop_d;
    logic squash_q, squash_d;
    logic done_q, done_d;

    // decode helpers
    logic [3:0] opc;
    logic take;
    logic bit_zero;
    // operation of the offered word
    boiu_op_e op_dec;
    // value after the selected bit is forced
    logic [DW-1:0] mod_val;

    // opcode field of the offered word
    assign opc = insn_word[OPC_MSB:OPC_LSB];

    // a word is taken in phase one while it is offered
    assign take = (phase_q == BOIU_Q1) && insn_valid;

    // set when the tested bit of the value read in phase two is zero
    assign bit_zero = !data_q[bsel_q];

    // opcode decode; a squashed word decodes as no-operation
    always_comb begin
        if (squash_q) begin
            op_dec = BOIU_OP_NONE;
        end else begin
            unique case (opc)
                OPC_BIT_CLEAR: op_dec = BOIU_OP_CLEAR;
                OPC_BIT_SET: op_dec = BOIU_OP_SET;
                OPC_BIT_TEST_CLEAR: op_dec = BOIU_OP_TEST;
                default: op_dec = BOIU_OP_NONE;
            endcase
        end
    end

    // phase sequencer: q1 waits for a word, then q2, q3 and q4
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            BOIU_Q1: begin
                if (insn_valid) begin
                    phase_d = BOIU_Q2;
                end
            end
            BOIU_Q2: begin
                phase_d = BOIU_Q3;
            end
            BOIU_Q3: begin
                phase_d = BOIU_Q4;
            end
            BOIU_Q4: begin
                phase_d = BOIU_Q1;
            end
        endcase
    end

    // phase register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phase_q <= BOIU_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    // operand latch: opcode and fields held for the whole instruction
    always_comb begin
        op_d = op_q;
        addr_d = addr_q;
        bsel_d = bsel_q;
        if (take) begin
            op_d = op_dec;
            addr_d = AW'(insn_word[ADDR_MSB:ADDR_LSB]);
            bsel_d = insn_word[BSEL_MSB:BSEL_LSB];
        end
    end

    // operand registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            op_q <= BOIU_OP_NONE;
            addr_q <= '0;
            bsel_q <= '0;
        end else begin
            op_q <= op_d;
            addr_q <= addr_d;
            bsel_q <= bsel_d;
        end
    end

    // per-bit modify: only the selected bit may change
    for (genvar gi = 0; gi < DW; gi++) begin : g_bit
        logic hit;
        assign hit = (bsel_q == BSEL_W'(gi)) && ((op_q == BOIU_OP_CLEAR) || (op_q == BOIU_OP_SET));
        // clear forces zero, set forces one
        assign mod_val[gi] = hit ? (op_q == BOIU_OP_SET) : data_q[gi];
    end

    // datapath: read in q2, modify in q3, write pulse in q4
    always_comb begin
        data_d = data_q;
        wr_d = wr_q;
        wr_en_d = 1'b0;
        if (phase_q == BOIU_Q2) begin
            data_d = reg_rd_data;
        end
        if (phase_q == BOIU_Q3) begin
            wr_d = mod_val;
            unique case (op_q)
                BOIU_OP_CLEAR: wr_en_d = 1'b1;
                BOIU_OP_SET: wr_en_d = 1'b1;
                BOIU_OP_TEST: wr_en_d = 1'b0;
                BOIU_OP_NONE: wr_en_d = 1'b0;
            endcase
        end
    end

    // datapath registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            data_q <= '0;
            wr_q <= '0;
            wr_en_q <= 1'b0;
        end else begin
            data_q <= data_d;
            wr_q <= wr_d;
            wr_en_q <= wr_en_d;
        end
    end

    // sequencer flags: done and skip pulses, squash of the next word
    always_comb begin
        skip_d = 1'b0;
        done_d = 1'b0;
        nop_d = nop_q;
        squash_d = squash_q;
        if (take) begin
            nop_d = squash_q;
            squash_d = 1'b0;
        end
        if (phase_q == BOIU_Q4) begin
            done_d = 1'b1;
            if ((op_q == BOIU_OP_TEST) && bit_zero) begin
                skip_d = 1'b1;
                squash_d = 1'b1;
            end
        end
    end

    // sequencer registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            skip_q <= 1'b0;
            nop_q <= 1'b0;
            squash_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
            nop_q <= nop_d;
            squash_q <= squash_d;
            done_q <= done_d;
        end
    end

    // register file side
    assign reg_addr = addr_q;
    assign reg_rd_en = (phase_q == BOIU_Q2) && (op_q != BOIU_OP_NONE);
    assign reg_wr_en = wr_en_q;
    assign reg_wr_data = wr_q;

    // sequencer side
    assign phase = phase_q;
    assign insn_done = done_q;
    assign skip_next = skip_q;
    assign nop_cycle = nop_q;
endmodule

/* boiu_sva.sv */
// assertions on the bit-operation unit ports
`timescale 1ns/1ps
module boiu_sva import boiu_pkg::*; #(parameter int DW = DATA_W, parameter int AW = ADDR_W) (
    input wire logic clk_sys, reset, insn_valid, reg_rd_en, reg_wr_en, insn_done, skip_next, nop_cycle,
    input wire logic [INSN_W-1:0] insn_word,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_rd_data, reg_wr_data,
    input wire logic [1:0] phase);
    logic [INSN_W-1:0] w_q;
    logic [DW-1:0] r_q;
    logic sq_q;
    always_ff @(posedge clk_sys) begin
        if (phase == 2'h0 && insn_valid) w_q <= insn_word;
        if (reg_rd_en) r_q <= reg_rd_data;
        if (reset || (phase == 2'h0 && insn_valid)) sq_q <= 1'b0;
        else if (skip_next) sq_q <= 1'b1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_clr; reg_wr_en && w_q[13:10] == 4'h4 |-> reg_wr_data == (r_q & ~(8'h1 << w_q[9:7])); endproperty
    a_clr: assert property (p_clr) else $error("bad clear");
    property p_set; reg_wr_en && w_q[13:10] == 4'h5 |-> reg_wr_data == (r_q | (8'h1 << w_q[9:7])); endproperty
    a_set: assert property (p_set) else $error("bad set");
    property p_skip; insn_done && !nop_cycle |-> skip_next == (w_q[13:10] == 4'h6 && !r_q[w_q[9:7]]); endproperty
    a_skip: assert property (p_skip) else $error("bad skip");
    property p_addr; reg_rd_en |-> reg_addr == w_q[6:0] && phase == 2'h1; endproperty
    a_addr: assert property (p_addr) else $error("bad address");
    property p_nop; (skip_next || sq_q) && phase == 2'h0 && insn_valid
        |=> (nop_cycle && !reg_rd_en && !reg_wr_en) [*4]; endproperty
    a_nop: assert property (p_nop) else $error("bad squash");
    property p_cyc; phase == 2'h0 && insn_valid && !skip_next && !sq_q && insn_word[13:11] == 3'h2
        |=> reg_rd_en ##2 reg_wr_en ##1 insn_done; endproperty
    a_cyc: assert property (p_cyc) else $error("bad timing");
    cover property (skip_next);
    cover property (reg_wr_en);
    cover property (nop_cycle);
endmodule
bind boiu_bit_op_unit boiu_sva #(.DW(DW), .AW(AW)) boiu_sva_i (.*);

/* boiu_regfile_model.sv */
// register file answering the unit's reads and writes
`timescale 1ns/1ps
module boiu_regfile_model (
    input wire logic clk_sys, rd_en, wr_en,
    input wire logic [6:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data);
    logic [7:0] mem [128];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    assign rd_data = rd_en ? mem[addr] : ~mem[addr];
    always @(posedge clk_sys) if (wr_en) mem[addr] <= wr_data;
endmodule

/* tb.sv */
// self-checking bench for the bit-operation unit
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; $display("wrong value %0t %h %h", $time, a, e); end end
module tb;
    import boiu_pkg::*;
    logic clk_sys = 0, reset = 1, insn_valid = 0, reg_rd_en, reg_wr_en, insn_done, skip_next, nop_cycle;
    logic [13:0] insn_word = '0, w;
    logic [6:0] reg_addr;
    logic [7:0] reg_rd_data, reg_wr_data;
    logic [1:0] phase;
    int miscompares = 0, tests_run = 0, m[128], op, b, a, v, ed;
    bit ew, es, sq, pes, st;
    boiu_bit_op_unit boiu_bit_op_unit_i (.*);
    boiu_regfile_model boiu_regfile_model_i (.clk_sys, .rd_en(reg_rd_en), .wr_en(reg_wr_en),
        .addr(reg_addr), .wr_data(reg_wr_data), .rd_data(reg_rd_data));
    task results;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #50 clk_sys = ~clk_sys;
    initial begin
        #1ms;
        miscompares++;
        results;
    end
    initial begin
        void'($urandom(60513));
        for (int i = 0; i < 128; i++) m[i] = (i * 37) & 255;
        repeat (16) @(posedge clk_sys);
        reset <= 0;
        for (int i = 0; i <= 200; i++) begin
            w = $urandom;
            op = $urandom % 4 == 3 ? $urandom % 16 : 4 + $urandom % 3;
            w[13:10] = op;
            st = $urandom % 4 == 0;
            insn_word <= w;
            insn_valid <= !st;
            #1;
            if (i) `CHK(insn_done, 1'b1)
            if (i) `CHK(skip_next, pes)
            if (st) begin
                @(posedge clk_sys);
                insn_valid <= 1;
                #1;
                `CHK(phase, 2'h0)
                `CHK(insn_done, 1'b0)
            end
            b = w[9:7];
            a = w[6:0];
            v = m[a];
            ew = !sq && (op == 4 || op == 5);
            ed = op == 4 ? v & ~(1 << b) : v | (1 << b);
            es = !sq && op == 6 && !v[b];
            if (ew) m[a] = ed;
            repeat (3) @(posedge clk_sys);
            #1;
            `CHK(nop_cycle, sq)
            `CHK(reg_wr_en, ew)
            `CHK(reg_addr, a[6:0])
            if (ew) `CHK(reg_wr_data, ed[7:0])
            pes = es;
            sq = es;
            @(posedge clk_sys);
        end
        results;
    end
endmodule
